// File: jtag_host.sv
// Model of the external scan controller: test clock, mode select, data in.
// Assumes data out arrives already resolved (z while undriven).
`timescale 1ns/1ns
`default_nettype none
module jtag_host (
    input wire logic clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // Clock stands low outside frames; lines rest at pull-up level
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One period of 4 CLK low, 4 high; data out read late in the high half
    task automatic step(input logic m, input logic d, output logic q);
    begin
        tms = m;
        tdi = d;
        repeat (4) @(posedge clk);
        #1 tck = 1'b1;
        repeat (4) @(posedge clk);
        #1 q = tdo;
        tck = 1'b0;
    end
    endtask
    // Five high edges reach reset, then one low edge to idle
    task automatic tms_reset();
    logic q;
    begin
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    end
    endtask
    // From idle: shift n bits LSB first through IR or DR, update, idle
    task automatic scan(input logic ir, input int n, input logic [tap_pkg::BSR_LEN-1:0] din,
        output logic [tap_pkg::BSR_LEN-1:0] dout);
    logic q;
    begin
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    end
    endtask
endmodule // jtag_host
`default_nettype wire

// File: scan_tap.sv
// Boundary-scan test port of the memory, plus the small FIFO that carries
// sampled test-clock rising-edge events to the controller.
// Assumes CLK is much faster than the test clock (half period >= 4 CLK).
//
// Behaviour
// [RL1] Sample inputs on rise, drive outputs on fall
// [RL2] Mode select steers controller, floats high
// [RL3] Data in feeds selected register MSB
// [RL4] Data out from LSB, changes on fall
// [RL5] Data out driven only while shifting
// [RL6] Five high mode-select edges reach reset
// [RL7] Test reset leaves memory operation untouched
// [RL8] Power-up reset leaves data out undriven
// [RL9] Exactly one data register selected at once
// [RL10] Three-bit serially shifted instruction register
// [RL11] Identification instruction after power-up and reset
// [RL12] Instruction capture loads binary 01
// [RL13] One-bit bypass register available
// [RL14] Bypass cell cleared when bypass applied
// [RL15] Boundary register covers all pins
// [RL16] Boundary captures ring, then shifts
// [RL17] Three instructions select and capture boundary
// [RL18] Identification capture loads 32-bit value
// [RL19] Identification value hardwired, shifted in shift
// [RL20] Unused port: hold test clock low
// [RL21] New instruction applies at instruction update
// [RL22] Sample-Z forces output bus undriven
// [RL23] Cell 108 gates bus in external test
// [RL24] Bypass instruction shifts through bypass cell
// [RL25] Standard sixteen-state controller on rising edges
// [RL26] Reserved encodings behave as bypass
`timescale 1ns/1ns
`default_nettype none

module tap_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Honest flags from the fill count
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer wrap without assuming a power-of-two depth
    always_comb
    begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
        end
        if (pop)
        begin
            rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Storage is plain flops; no reset needed on data
    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else if (ce)
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule // tap_fifo

module scan_tap #(
    parameter logic [31:0] ID_VALUE = 32'h0a5c_3e01 // Arbitrary value
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic [tap_pkg::BSR_LEN-1:0] PIN_RING,
    output logic TDO,
    output logic TDO_OE,
    output logic Q_BUS_OE,
    output logic EXTEST_DRIVE,
    output logic [tap_pkg::BSR_LEN-1:0] BSR_OUT
);
    // Controller next state, standard diagram
    function automatic tap_pkg::tap_st_t next_st(tap_pkg::tap_st_t s, logic m);
        case (s)
            tap_pkg::ST_RESET: next_st = m ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE: next_st = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR: next_st = m ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR: next_st = m ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_SH_DR: next_st = m ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_EX1_DR: next_st = m ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PA_DR;
            tap_pkg::ST_PA_DR: next_st = m ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PA_DR;
            tap_pkg::ST_EX2_DR: next_st = m ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_UPD_DR: next_st = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR: next_st = m ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR: next_st = m ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
            tap_pkg::ST_SH_IR: next_st = m ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
            tap_pkg::ST_EX1_IR: next_st = m ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PA_IR;
            tap_pkg::ST_PA_IR: next_st = m ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PA_IR;
            tap_pkg::ST_EX2_IR: next_st = m ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
            tap_pkg::ST_UPD_IR: next_st = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            default: next_st = tap_pkg::ST_RESET;
        endcase
    endfunction

    // Data register chosen by an instruction; reserved codes fall to bypass
    function automatic tap_pkg::dsel_t dr_sel(logic [tap_pkg::IR_W-1:0] ins);
        case (ins)
            tap_pkg::INS_EXTEST, tap_pkg::INS_SAMPLE,
            tap_pkg::INS_SAMPLE_Z: dr_sel = tap_pkg::SEL_BSR; // [RL17]
            tap_pkg::INS_IDCODE: dr_sel = tap_pkg::SEL_ID;
            default: dr_sel = tap_pkg::SEL_BYP; // [RL26]
        endcase
    endfunction

    logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
    logic [tap_pkg::BSR_LEN-1:0] pin_s1, pin_s2;
    logic rise, fall;
    logic ev_pend_r, ev_pend_nxt;
    logic [tap_pkg::EV_W-1:0] ev_data_r, ev_data_nxt, ev_out;
    logic ev_ready, ev_valid, ev_take;
    logic busy_r, busy_nxt;
    tap_pkg::tap_st_t st_r, st_nxt;
    tap_pkg::dsel_t sel;
    logic [tap_pkg::IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
    logic byp_r, byp_nxt;
    logic [tap_pkg::ID_W-1:0] id_sh_r, id_sh_nxt;
    logic [tap_pkg::BSR_LEN-1:0] bsr_sh_r, bsr_sh_nxt, bsr_upd_r, bsr_upd_nxt;
    logic tdo_r, tdo_nxt, oe_r, oe_nxt, qoe_r, qoe_nxt, ext_r, ext_nxt;
    logic shifting;

    // Two-flop synchronisers; the second stage is read, and for the test clock the third stage too
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end
        else if (CE)
        begin
            tck_s1 <= TCK;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= TMS;
            tms_s2 <= tms_s1;
            tdi_s1 <= TDI;
            tdi_s2 <= tdi_s1;
            pin_s1 <= PIN_RING;
            pin_s2 <= pin_s1;
        end
    end

    // Test clock edges; a clock held low never advances anything
    assign rise = tck_s2 && !tck_s3; // [RL20]
    assign fall = !tck_s2 && tck_s3;

    // Rising-edge samples wait here until the FIFO takes them
    always_comb
    begin
        ev_pend_nxt = ev_pend_r;
        ev_data_nxt = ev_data_r;
        if (ev_pend_r && ev_ready)
        begin
            ev_pend_nxt = 1'b0;
        end
        if (rise)
        begin
            ev_pend_nxt = 1'b1;
            ev_data_nxt = {tms_s2, tdi_s2}; // [RL1] [RL2]
        end
    end

    tap_fifo #(
        .WIDTH(tap_pkg::EV_W),
        .DEPTH(tap_pkg::EV_DEPTH)
    ) u_ev_fifo (
        .clk(CLK),
        .resetn(RESETN),
        .ce(CE),
        .in_valid(ev_pend_r),
        .in_ready(ev_ready),
        .in_data(ev_data_r),
        .out_valid(ev_valid),
        .out_ready(!busy_r),
        .out_data(ev_out)
    );

    // Controller takes at most one event every other cycle
    assign ev_take = ev_valid && !busy_r;
    assign sel = dr_sel(ir_r); // [RL9]
    assign shifting = (st_r == tap_pkg::ST_SH_DR) || (st_r == tap_pkg::ST_SH_IR);

    // Rising-edge work uses the state before the transition
    always_comb
    begin
        busy_nxt = ev_take;
        st_nxt = st_r;
        ir_nxt = ir_r;
        ir_sh_nxt = ir_sh_r;
        byp_nxt = byp_r;
        id_sh_nxt = id_sh_r;
        bsr_sh_nxt = bsr_sh_r;
        bsr_upd_nxt = bsr_upd_r;
        tdo_nxt = tdo_r;
        oe_nxt = oe_r;
        if (ev_take)
        begin
            case (st_r)
                tap_pkg::ST_CAP_IR: ir_sh_nxt = tap_pkg::IR_CAPTURE; // [RL12]
                tap_pkg::ST_SH_IR: ir_sh_nxt = {ev_out[0], ir_sh_r[2:1]}; // [RL10] [RL3]
                tap_pkg::ST_CAP_DR:
                begin
                    if (sel == tap_pkg::SEL_BSR)
                    begin
                        bsr_sh_nxt = pin_s2; // [RL16] [RL15]
                    end
                    else if (sel == tap_pkg::SEL_ID)
                    begin
                        id_sh_nxt = ID_VALUE; // [RL18] [RL19]
                    end
                    else
                    begin
                        byp_nxt = 1'b0; // [RL13]
                    end
                end
                tap_pkg::ST_SH_DR:
                begin
                    if (sel == tap_pkg::SEL_BSR)
                    begin
                        bsr_sh_nxt = {ev_out[0], bsr_sh_r[tap_pkg::BSR_LEN-1:1]}; // [RL16]
                    end
                    else if (sel == tap_pkg::SEL_ID)
                    begin
                        id_sh_nxt = {ev_out[0], id_sh_r[tap_pkg::ID_W-1:1]}; // [RL19]
                    end
                    else
                    begin
                        byp_nxt = ev_out[0]; // [RL24] [RL3]
                    end
                end
                default: ;
            endcase
            st_nxt = next_st(st_r, ev_out[1]); // [RL25] [RL6]
        end
        // Falling-edge work: updates, reset defaults and the data out pin
        if (fall)
        begin
            case (st_r)
                tap_pkg::ST_RESET:
                begin
                    ir_nxt = tap_pkg::IR_RST; // [RL11]
                    bsr_upd_nxt[tap_pkg::OE_CELL] = 1'b1; // [RL23]
                end
                tap_pkg::ST_UPD_IR:
                begin
                    ir_nxt = ir_sh_r; // [RL21]
                    if (dr_sel(ir_sh_r) == tap_pkg::SEL_BYP)
                    begin
                        byp_nxt = 1'b0; // [RL14]
                    end
                end
                tap_pkg::ST_UPD_DR:
                begin
                    if (sel == tap_pkg::SEL_BSR)
                    begin
                        bsr_upd_nxt = bsr_sh_r;
                    end
                end
                default: ;
            endcase
            oe_nxt = shifting; // [RL5]
            if (st_r == tap_pkg::ST_SH_IR)
            begin
                tdo_nxt = ir_sh_r[0]; // [RL4]
            end
            else if (st_r == tap_pkg::ST_SH_DR)
            begin
                case (sel)
                    tap_pkg::SEL_BSR: tdo_nxt = bsr_sh_r[0]; // [RL4]
                    tap_pkg::SEL_ID: tdo_nxt = id_sh_r[0];
                    default: tdo_nxt = byp_r;
                endcase
            end
        end
    end

    // Memory-side controls; normal operation keeps the bus enabled [RL7]
    always_comb
    begin
        ext_nxt = (ir_r == tap_pkg::INS_EXTEST);
        if (ir_r == tap_pkg::INS_SAMPLE_Z)
        begin
            qoe_nxt = 1'b0; // [RL22]
        end
        else if (ext_nxt)
        begin
            qoe_nxt = bsr_upd_r[tap_pkg::OE_CELL]; // [RL23]
        end
        else
        begin
            qoe_nxt = 1'b1;
        end
    end

    // Power-up reset puts the port in its reset state, data out undriven
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ev_pend_r <= 1'b0;
            ev_data_r <= '0;
            busy_r <= 1'b0;
            st_r <= tap_pkg::ST_RESET;
            ir_r <= tap_pkg::IR_RST; // [RL11]
            ir_sh_r <= '0;
            byp_r <= 1'b0;
            id_sh_r <= '0;
            bsr_sh_r <= '0;
            bsr_upd_r <= tap_pkg::BSR_UPD_RST; // [RL23]
            tdo_r <= 1'b0;
            oe_r <= 1'b0; // [RL8]
            qoe_r <= 1'b1;
            ext_r <= 1'b0;
        end
        else if (CE)
        begin
            ev_pend_r <= ev_pend_nxt;
            ev_data_r <= ev_data_nxt;
            busy_r <= busy_nxt;
            st_r <= st_nxt;
            ir_r <= ir_nxt;
            ir_sh_r <= ir_sh_nxt;
            byp_r <= byp_nxt;
            id_sh_r <= id_sh_nxt;
            bsr_sh_r <= bsr_sh_nxt;
            bsr_upd_r <= bsr_upd_nxt;
            tdo_r <= tdo_nxt;
            oe_r <= oe_nxt;
            qoe_r <= qoe_nxt;
            ext_r <= ext_nxt;
        end
    end

    assign TDO = tdo_r;
    assign TDO_OE = oe_r;
    assign Q_BUS_OE = qoe_r;
    assign EXTEST_DRIVE = ext_r;
    assign BSR_OUT = bsr_upd_r;
endmodule // scan_tap
`default_nettype wire

// File: scan_tap_properties.sv
// Checker for the scan test port, bound to the top module.
// Assumes CLK runs well above the test clock, as the port needs.
`timescale 1ns/1ns
`default_nettype none
module scan_tap_props (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDO,
    input wire logic TDO_OE,
    input wire logic Q_BUS_OE,
    input wire logic EXTEST_DRIVE,
    input wire logic [tap_pkg::BSR_LEN-1:0] BSR_OUT
);
    logic tck_r, tck_nxt;
    logic [3:0] age_r, age_nxt;
    logic [2:0] hi_r, hi_nxt;
    // Cycles since a test clock fall; run of rises with mode select high
    always_comb
    begin
        tck_nxt = TCK;
        age_nxt = (tck_r && !TCK) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
        hi_nxt = hi_r;
        if (!tck_r && TCK)
            hi_nxt = TMS ? hi_r + {2'h0, hi_r != 3'h7} : 3'h0;
    end
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tck_r <= 1'b0;
            age_r <= 4'hf;
            hi_r <= 3'h0;
        end
        else
        begin
            tck_r <= tck_nxt;
            age_r <= age_nxt;
            hi_r <= hi_nxt;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Outputs move only in the few cycles after a test clock fall
    a_tdo_on_fall: assert property ($changed(TDO) |-> age_r <= 4'h6)
        else $error("data out moved away from a test clock fall");
    a_oe_on_fall: assert property ($changed(TDO_OE) |-> age_r <= 4'h6)
        else $error("data out enable moved away from a fall");
    a_instr_on_fall: assert property ($changed(EXTEST_DRIVE) |-> age_r <= 4'h6)
        else $error("instruction changed away from a fall");
    a_bsr_on_fall: assert property ($changed(BSR_OUT) |-> age_r <= 4'h6)
        else $error("boundary update changed away from a fall");
    a_bus_on_fall: assert property ($changed(Q_BUS_OE) |-> age_r <= 4'h7)
        else $error("bus enable changed away from a fall");
    a_reset_values: assert property ($rose(RESETN) |-> !TDO_OE && Q_BUS_OE
        && !EXTEST_DRIVE && BSR_OUT == tap_pkg::BSR_UPD_RST)
        else $error("wrong values after power-up reset");
    a_ext_gates_bus: assert property (EXTEST_DRIVE && $past(EXTEST_DRIVE)
        && $stable(BSR_OUT[108]) |-> Q_BUS_OE == BSR_OUT[108])
        else $error("bus enable does not follow cell 108 in external test");
    a_tms_reset: assert property ($fell(TCK) && hi_r >= 3'h5 |-> ##7 (!EXTEST_DRIVE
        && Q_BUS_OE && BSR_OUT[tap_pkg::OE_CELL]))
        else $error("five high mode-select edges did not reset the port");
    c_shift: cover property ($rose(TDO_OE));
    c_extest: cover property ($rose(EXTEST_DRIVE));
    c_bus_off: cover property ($fell(Q_BUS_OE));
endmodule // scan_tap_props
bind scan_tap scan_tap_props i_props (.CLK(CLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS),
    .TDO(TDO), .TDO_OE(TDO_OE), .Q_BUS_OE(Q_BUS_OE), .EXTEST_DRIVE(EXTEST_DRIVE),
    .BSR_OUT(BSR_OUT));
`default_nettype wire

// File: scan_tap_tb_top.sv
// Self-checking bench for the scan test port and its event FIFO.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module scan_tap_tb_top;
    localparam logic [31:0] ID_EXP = 32'h5e3c_a017; // Arbitrary value
    localparam int N = tap_pkg::BSR_LEN;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [N-1:0] pin_ring = '0;
    logic tdo, tdo_oe, q_bus_oe, extest_drive;
    logic [N-1:0] bsr_out;
    wire tck, tms, tdi, tdo_w;
    int failures = 0;
    int comparisons = 0;
    logic [2:0] byp_codes [4] = '{tap_pkg::INS_BYPASS, 3'h3, 3'h5, 3'h6};
    logic [2:0] bsr_codes [3] = '{tap_pkg::INS_SAMPLE, tap_pkg::INS_SAMPLE_Z,
        tap_pkg::INS_EXTEST};
    logic [N-1:0] loads [3] = '{{1'b1, {27{4'h5}}}, {1'b0, {27{4'ha}}}, {1'b1, {27{4'h3}}}};
    logic bus_ir [3] = '{1'b1, 1'b0, 1'b0};
    logic bus_dr [3] = '{1'b1, 1'b0, 1'b1};
    always #50 clk = ~clk;
    // Data out floats while undriven, so a late enable reads as z
    assign tdo_w = tdo_oe ? tdo : 1'bz;
    scan_tap #(.ID_VALUE(ID_EXP)) i_dut (.CLK(clk), .RESETN(resetn), .CE(ce), .TCK(tck),
        .TMS(tms), .TDI(tdi), .PIN_RING(pin_ring), .TDO(tdo), .TDO_OE(tdo_oe),
        .Q_BUS_OE(q_bus_oe), .EXTEST_DRIVE(extest_drive), .BSR_OUT(bsr_out));
    jtag_host i_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));
    task automatic check(input string what, input logic [N-1:0] exp, input logic [N-1:0] got);
    begin
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task automatic print_verdict();
    begin
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // Watchdog well beyond the expected run of about 0.53 ms
    initial
    begin
        #2000000;
        failures++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        logic [N-1:0] got;
        logic [N-1:0] ring;
        ring = {1'b1, {27{4'h6}}};
        repeat (8) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1 check("tdo_oe", 1'b0, tdo_oe);
        check("q_bus_oe", 1'b1, q_bus_oe);
        check("bsr_out", tap_pkg::BSR_UPD_RST, bsr_out);
        check("extest_drive", 1'b0, extest_drive);
        // Identification code after power-up; the event FIFO is used through the top
        i_host.tms_reset();
        i_host.scan(1'b0, 32, '0, got);
        check("idcode", ID_EXP, got[31:0]);
        check("tdo_oe idle", 1'b0, tdo_oe);
        // Bypass and reserved codes: one-bit path, captured zero first
        foreach (byp_codes[k])
        begin
            i_host.scan(1'b1, 3, {106'h0, byp_codes[k]}, got);
            check("ir capture", 2'h1, got[1:0]);
            check("q_bus_oe bypass", 1'b1, q_bus_oe);
            i_host.scan(1'b0, 4, {105'h0, 4'h5}, got);
            check("bypass path", 4'ha, got[3:0]);
        end
        // Clock enable low freezes the port; state must survive the pause
        ce = 1'b0;
        repeat (20) @(posedge clk);
        #1 check("tdo_oe frozen", 1'b0, tdo_oe);
        ce = 1'b1;
        // Boundary instructions capture the ring and update on the fall
        pin_ring = ring;
        foreach (bsr_codes[k])
        begin
            i_host.scan(1'b1, 3, {106'h0, bsr_codes[k]}, got);
            check("q_bus_oe ir", bus_ir[k], q_bus_oe);
            check("extest_drive", k == 2, extest_drive);
            i_host.scan(1'b0, N, loads[k], got);
            check("ring capture", ring, got);
            check("bsr_out", loads[k], bsr_out);
            check("q_bus_oe dr", bus_dr[k], q_bus_oe);
        end
        i_host.scan(1'b0, N, {1'b0, {27{4'h9}}}, got);
        check("q_bus_oe off", 1'b0, q_bus_oe);
        // Test reset restores the identification code and cell 108
        i_host.tms_reset();
        check("extest_drive", 1'b0, extest_drive);
        check("cell 108", 1'b1, bsr_out[108]);
        check("q_bus_oe", 1'b1, q_bus_oe);
        i_host.scan(1'b1, 3, {106'h0, tap_pkg::INS_EXTEST}, got);
        // Power-up reset in mid-run
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1 check("bsr_out", tap_pkg::BSR_UPD_RST, bsr_out);
        check("extest_drive", 1'b0, extest_drive);
        i_host.tms_reset();
        i_host.scan(1'b0, 32, '0, got);
        check("idcode", ID_EXP, got[31:0]);
        print_verdict();
    end
endmodule // scan_tap_tb_top
`default_nettype wire

// File: tap_pkg.sv
// Constants shared by the boundary-scan test port and its event FIFO.
// Assumes nothing of its surroundings; holds definitions only.
`default_nettype none
package tap_pkg;
    // Register sizes
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_LEN = 109;
    localparam int OE_CELL = 108;
    // Event FIFO shape: one word is {mode select, data in}
    localparam int EV_W = 2;
    localparam int EV_DEPTH = 4;
    // Instruction encodings
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    // Value loaded into the instruction shifter on capture
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    // Reset values
    localparam logic [BSR_LEN-1:0] BSR_UPD_RST = {1'b1, 108'h0};
    localparam logic [IR_W-1:0] IR_RST = INS_IDCODE;
    // Data register selection
    typedef enum logic [2:0] {
        SEL_BYP = 3'h1,
        SEL_ID = 3'h2,
        SEL_BSR = 3'h4
    } dsel_t;
    // Controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } tap_st_t;
endpackage
`default_nettype wire
